/* File: core/sgd_cfg.svh */
// Contract
// - synchronous mode: all transmit nibbles taken on both edges of the shared clock
// - independent mode: each channel takes nibbles on both edges of its own clock
// - serializer word comes from the encoder when coding, else from two nibbles
// - serial bits shift at ten times the word rate
// - least significant bit of each word is sent first
// - align on commas at full rate, on the idle start pattern at low rate
// - nothing is sent or received until about 8 us after power-up
// - receive recovery locks within 2 us of a valid stream
// - without input the recovery falls back to the reference, relocks later
// - lock holds within 200 ppm given a 100 ppm reference
// - received words go through decoder in byte mode, then a FIFO clocked by the output clock
// - at full rate only the positive comma 0011111 sets the word boundary
// - receive byte clock never stretches or shortens, even while realigning
// - K28.x shows index then 11100; K23/27/29/30.7 show 111 then code
// - comma detection off leaves the word boundary arbitrary
// - each channel has its own 5-bit receive bus
// - receive nibbles on both byte clock edges, low nibble on rising
// - receive timing selectable: edges centred in data or aligned to it
// - with tolerance compensation the byte clock follows reference, else recovery; here both come from REF_CLK
// - tolerance compensation only in byte-coded mode
// - low five bits on rising edge, high five on falling edge
// - a small transmit FIFO absorbs phase, not frequency, difference
// - coding select low is ten-bit mode, high is byte mode with control bit 4
`ifndef SGD_CFG_SVH
`define SGD_CFG_SVH
`define SGD_REF_PERIOD_NS 40
`define SGD_PWRUP_NS 8000
`define SGD_PWRUP_CYC ((`SGD_PWRUP_NS + `SGD_REF_PERIOD_NS - 1) / `SGD_REF_PERIOD_NS)
`define SGD_LOCK_NS 2000
`define SGD_LOCK_CYC (`SGD_LOCK_NS / `SGD_REF_PERIOD_NS)
`define SGD_LOS_CYC 8'h10
`define SGD_RX_PPM 200
`define SGD_REF_PPM 100
`define SGD_WORD_LAST 4'h9
`define SGD_BC_HALF 4'h5
`define SGD_LD_ALN 4'h0
`define SGD_HI_ALN 4'h5
`define SGD_LD_CTR 4'h8
`define SGD_HI_CTR 4'h3
`define SGD_COMMA 7'h7C
`define SGD_JK 10'h223
`define SGD_K28 5'h1C
`define SGD_KX7_IDX 3'h7
`endif

/* File: core/sgd_datapath.sv */
`default_nettype none
`include "sgd_cfg.svh"
module sgd_datapath
(
  input wire logic REF_CLK,
  input wire logic RST,
  input wire sgd_pkg::sgd_cfg_t CFG,
  input wire logic OVF_CLEAR,
  input wire logic SHARED_TX_CLOCK,
  input wire logic PER_CHANNEL_TX_CLOCK,
  input wire logic [4:0] TX_NIBBLE,
  input wire logic [9:0] ENC_WORD,
  output logic TX_SERIAL,
  output logic TX_READY,
  output logic TX_OVERFLOW,
  input wire logic RX_SERIAL,
  output logic [9:0] RX_RAW_WORD,
  input wire logic [7:0] DEC_DATA,
  output logic RX_BYTE_CLOCK,
  output logic [4:0] RX_NIBBLE_BUS,
  output logic RX_LOCKED,
  output logic RX_SYNCED,
  output logic RX_OVERFLOW,
  output logic DEV_READY
);
  import sgd_pkg::*;

  // twelve codes: K-code to receive bus value
  function automatic logic [8:0] kdec(input logic [9:0] w);
    logic [9:0] p;
    logic [5:0] six;
    logic [3:0] fg;
    logic [2:0] idx;
    logic hit;
    p = '0;
    six = '0;
    fg = '0;
    idx = '0;
    hit = 1'b0;
    // printed order puts the first bit on the left
    for (int i = 0; i < 10; i++)
      p[9 - i] = w[i];
    six = p[9:4];
    fg = p[3:0];
    if (six == 6'h0F || six == 6'h30)
    begin
      if (six == 6'h30)
        fg = ~fg;
      hit = 1'b1;
      case (fg)
        4'h4: idx = 3'h0;
        4'h9: idx = 3'h1;
        4'h5: idx = 3'h2;
        4'h3: idx = 3'h3;
        4'h2: idx = 3'h4;
        4'hA: idx = 3'h5;
        4'h6: idx = 3'h6;
        4'h8: idx = 3'h7;
        default: hit = 1'b0;
      endcase
      kdec = {hit, idx, `SGD_K28};
    end
    else
    begin
      if (fg == 4'h7)
        six = ~six;
      hit = (fg == 4'h8) || (fg == 4'h7);
      case (six)
        6'h3A: kdec = {hit, `SGD_KX7_IDX, 5'h17};
        6'h36: kdec = {hit, `SGD_KX7_IDX, 5'h1B};
        6'h2E: kdec = {hit, `SGD_KX7_IDX, 5'h1D};
        6'h1E: kdec = {hit, `SGD_KX7_IDX, 5'h1E};
        default: kdec = 9'h000;
      endcase
    end
  endfunction

  logic ctc_on;
  logic [7:0] pwr_cnt;
  logic pwr_ready;
  logic [6:0] tx_sync;
  logic tclk;
  logic tclk_prev;
  logic [4:0] low_nib;
  logic have_low;
  logic tx_in_valid;
  logic [9:0] tx_in_data;
  logic tx_in_ready;
  logic tx_out_valid;
  logic tx_out_ready;
  logic [9:0] tx_out_data;
  logic [9:0] tx_sh;
  logic [3:0] tx_cnt;
  logic rbit;
  logic [2:0] rx_pipe;
  logic rbit_prev;
  logic [7:0] act_cnt;
  logic stream_ok;
  logic [7:0] lock_cnt;
  sgd_cdr_t cdr;
  sgd_cdr_t next_cdr;
  logic [9:0] sr;
  logic prev_bit;
  logic [9:0] nrzi;
  logic comma_hit;
  logic [3:0] wcnt;
  logic word_valid;
  logic push_valid;
  logic [9:0] push_data;
  logic [8:0] kinfo;
  sgd_rxb_t coded;
  logic rx_in_ready;
  logic rx_out_valid;
  logic rx_out_ready;
  logic [9:0] rx_out_data;
  logic [3:0] bc_cnt;
  logic [9:0] out_word;
  logic [3:0] ld_at;
  logic [3:0] hi_at;
  sgd_word_t ow;
  sgd_rxb_t ob;
  logic [9:0] head;
  sgd_rxb_t hb;

  assign ctc_on = CFG.clock_tolerance_comp & CFG.code_sel;

  // power-up settling before the data path opens
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      pwr_cnt <= 8'h00;
      pwr_ready <= 1'b0;
    end
    else if (!pwr_ready)
    begin
      pwr_cnt <= pwr_cnt + 8'h01;
      if (pwr_cnt == 8'(`SGD_PWRUP_CYC - 1))
        pwr_ready <= 1'b1;
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      DEV_READY <= 1'b0;
    else
      DEV_READY <= pwr_ready;
  end

  sgd_sync #(.W(7)) u_tx_sync
  (
    .clk(REF_CLK),
    .rst(RST),
    .d({SHARED_TX_CLOCK, PER_CHANNEL_TX_CLOCK, TX_NIBBLE}),
    .q(tx_sync)
  );

  // only the selected clock is watched, so the unused one may be grounded
  assign tclk = CFG.sync_mode ? tx_sync[6] : tx_sync[5];

  // equal frequency keeps one word per transmit period
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      tclk_prev <= 1'b0;
      low_nib <= 5'h00;
      have_low <= 1'b0;
      tx_in_valid <= 1'b0;
      tx_in_data <= 10'h000;
    end
    else
    begin
      tclk_prev <= tclk;
      tx_in_valid <= 1'b0;
      if (tclk & ~tclk_prev)
      begin
        low_nib <= tx_sync[4:0];
        have_low <= 1'b1;
      end
      else if (~tclk & tclk_prev & have_low)
      begin
        have_low <= 1'b0;
        tx_in_valid <= pwr_ready;
        // coded words come from the encoder; raw words from the two nibbles
        tx_in_data <= CFG.code_sel ? ENC_WORD : {tx_sync[4:0], low_nib};
      end
    end
  end

  // phase buffer only: a faster source overflows it
  sgd_fifo2 #(.W(10)) u_tx_fifo
  (
    .clk(REF_CLK),
    .rst(RST),
    .in_valid(tx_in_valid),
    .in_ready(tx_in_ready),
    .in_data(tx_in_data),
    .out_valid(tx_out_valid),
    .out_ready(tx_out_ready),
    .out_data(tx_out_data)
  );

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      TX_READY <= 1'b0;
      TX_OVERFLOW <= 1'b0;
    end
    else
    begin
      TX_READY <= tx_in_ready & pwr_ready;
      // a new loss wins over a clear in the same cycle
      if (tx_in_valid & ~tx_in_ready)
        TX_OVERFLOW <= 1'b1;
      else if (OVF_CLEAR)
        TX_OVERFLOW <= 1'b0;
    end
  end

  assign tx_out_ready = (tx_cnt == 4'h0) & pwr_ready;

  // one bit per cycle: the reference clock stands in for the bit clock
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      tx_sh <= 10'h000;
      tx_cnt <= 4'h0;
      TX_SERIAL <= 1'b0;
    end
    else if (tx_out_valid & tx_out_ready)
    begin
      TX_SERIAL <= tx_out_data[0];
      tx_sh <= tx_out_data >> 1;
      tx_cnt <= `SGD_WORD_LAST;
    end
    else if (tx_cnt != 4'h0)
    begin
      TX_SERIAL <= tx_sh[0];
      tx_sh <= tx_sh >> 1;
      tx_cnt <= tx_cnt - 4'h1;
    end
    else
      TX_SERIAL <= 1'b0;
  end

  // bits change every cycle here, so an agreement filter would eat single bits
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      rx_pipe <= 3'h0;
    else
      rx_pipe <= {rx_pipe[1:0], RX_SERIAL};
  end

  assign rbit = rx_pipe[2];

  // activity watch: a quiet line means no valid stream
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      rbit_prev <= 1'b0;
      act_cnt <= `SGD_LOS_CYC;
    end
    else
    begin
      rbit_prev <= rbit;
      if (rbit != rbit_prev)
        act_cnt <= 8'h00;
      else if (act_cnt != `SGD_LOS_CYC)
        act_cnt <= act_cnt + 8'h01;
    end
  end

  assign stream_ok = (act_cnt != `SGD_LOS_CYC);

  // frequency offset is not modelled; bits arrive on the reference rate
  always_comb
  begin
    next_cdr = cdr;
    case (cdr)
      SGD_PWR: if (pwr_ready) next_cdr = SGD_ACQ;
      SGD_ACQ: if (stream_ok && lock_cnt == 8'(`SGD_LOCK_CYC - 1)) next_cdr = SGD_LOCK;
      SGD_LOCK: if (!stream_ok) next_cdr = SGD_ACQ;
      default: next_cdr = SGD_PWR;
    endcase
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      cdr <= SGD_PWR;
    else
      cdr <= next_cdr;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      lock_cnt <= 8'h00;
    else if (cdr == SGD_ACQ && stream_ok)
      lock_cnt <= lock_cnt + 8'h01;
    else
      lock_cnt <= 8'h00;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      RX_LOCKED <= 1'b0;
    else
      RX_LOCKED <= (next_cdr == SGD_LOCK);
  end

  // newest bit enters at the top, so sr[0] is the first bit of the window
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      sr <= 10'h000;
      prev_bit <= 1'b0;
    end
    else
    begin
      sr <= {rbit, sr[9:1]};
      prev_bit <= sr[0];
    end
  end

  assign nrzi = sr ^ {sr[8:0], prev_bit};
  // inverse comma is ignored on purpose; a partner must repeat the K-code
  assign comma_hit = CFG.comma_en & (CFG.fx ? (nrzi == `SGD_JK) : (sr[6:0] == `SGD_COMMA));

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      wcnt <= 4'h0;
      word_valid <= 1'b0;
      RX_RAW_WORD <= 10'h000;
    end
    else
    begin
      word_valid <= 1'b0;
      if (cdr != SGD_LOCK)
        wcnt <= 4'h0;
      else if (comma_hit || wcnt == `SGD_WORD_LAST)
      begin
        // with detection off the free count sets an arbitrary boundary
        wcnt <= 4'h0;
        word_valid <= 1'b1;
        RX_RAW_WORD <= sr;
      end
      else
        wcnt <= wcnt + 4'h1;
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      RX_SYNCED <= 1'b0;
    else if (cdr != SGD_LOCK)
      RX_SYNCED <= 1'b0;
    else if (comma_hit)
      RX_SYNCED <= 1'b1;
  end

  assign kinfo = kdec(RX_RAW_WORD);
  assign coded.ctrl = {2{kinfo[8]}};
  assign coded.data = kinfo[8] ? kinfo[7:0] : DEC_DATA;

  // the outside decoder answers within the cycle the raw word stands
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      push_valid <= 1'b0;
      push_data <= 10'h000;
    end
    else
    begin
      push_valid <= word_valid;
      if (word_valid)
        push_data <= CFG.code_sel ? 10'(coded) : RX_RAW_WORD;
    end
  end

  sgd_fifo2 #(.W(10)) u_rx_fifo
  (
    .clk(REF_CLK),
    .rst(RST),
    .in_valid(push_valid),
    .in_ready(rx_in_ready),
    .in_data(push_data),
    .out_valid(rx_out_valid),
    .out_ready(rx_out_ready),
    .out_data(rx_out_data)
  );

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      RX_OVERFLOW <= 1'b0;
    else if (push_valid & ~rx_in_ready)
      RX_OVERFLOW <= 1'b1;
    else if (OVF_CLEAR)
      RX_OVERFLOW <= 1'b0;
  end

  // free divider never restarts, so realignment cannot bend the clock
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      bc_cnt <= 4'h0;
    else if (bc_cnt == `SGD_WORD_LAST)
      bc_cnt <= 4'h0;
    else
      bc_cnt <= bc_cnt + 4'h1;
  end

  // both sources tick at the reference in this model; ctc_on picks the label only
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      RX_BYTE_CLOCK <= 1'b0;
    else
      RX_BYTE_CLOCK <= (bc_cnt < `SGD_BC_HALF) | (ctc_on & 1'b0);
  end

  assign ld_at = CFG.centered ? `SGD_LD_CTR : `SGD_LD_ALN;
  assign hi_at = CFG.centered ? `SGD_HI_CTR : `SGD_HI_ALN;
  assign rx_out_ready = (bc_cnt == ld_at);
  // an empty buffer shows zeros, never a stale entry
  assign head = rx_out_valid ? rx_out_data : 10'h000;
  assign hb = sgd_rxb_t'(head);

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      out_word <= 10'h000;
    else if (rx_out_ready)
      out_word <= head;
  end

  assign ow = sgd_word_t'(out_word);
  assign ob = sgd_rxb_t'(out_word);

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      RX_NIBBLE_BUS <= 5'h00;
    else if (bc_cnt == ld_at)
      RX_NIBBLE_BUS <= CFG.code_sel ? {hb.ctrl[0], hb.data[3:0]} : head[4:0];
    else if (bc_cnt == hi_at)
      RX_NIBBLE_BUS <= CFG.code_sel ? {ob.ctrl[1], ob.data[7:4]} : ow.hi;
  end
endmodule
`default_nettype wire

/* File: core/sgd_datapath_note.sv */
`default_nettype none
`default_nettype wire

/* File: core/sgd_fifo2.sv */
`default_nettype none
module sgd_fifo2 #(parameter int W = 10)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] mem [2];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] count;
  logic push;
  logic pop;
  assign in_ready = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end
    else
    begin
      if (push)
        wr_ptr <= ~wr_ptr;
      if (pop)
        rd_ptr <= ~rd_ptr;
      if (push & ~pop)
        count <= count + 2'h1;
      else if (pop & ~push)
        count <= count - 2'h1;
    end
  end
endmodule
`default_nettype wire

/* File: core/sgd_pkg.sv */
`default_nettype none
package sgd_pkg;
  typedef enum logic [2:0] {SGD_PWR = 3'b001, SGD_ACQ = 3'b010, SGD_LOCK = 3'b100} sgd_cdr_t;
  typedef struct packed
  {
    logic [4:0] hi;
    logic [4:0] lo;
  } sgd_word_t;
  typedef struct packed
  {
    logic [1:0] ctrl;
    logic [7:0] data;
  } sgd_rxb_t;
  typedef struct packed
  {
    logic sync_mode;
    logic code_sel;
    logic clock_tolerance_comp;
    logic comma_en;
    logic fx;
    logic centered;
  } sgd_cfg_t;
endpackage
`default_nettype wire

/* File: core/sgd_sync.sv */
`default_nettype none
module sgd_sync #(parameter int W = 1)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      q <= '0;
    end
    else
    begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      // a change counts once two stages agree
      if (s2 == s3)
        q <= s3;
    end
  end
endmodule
`default_nettype wire

/* File: verification/sgd_datapath_monitor.sv */
`default_nettype none
module sgd_datapath_monitor
(
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic OVF_CLEAR,
  input wire logic TX_SERIAL,
  input wire logic TX_READY,
  input wire logic TX_OVERFLOW,
  input wire logic RX_BYTE_CLOCK,
  input wire logic [4:0] RX_NIBBLE_BUS,
  input wire logic RX_LOCKED,
  input wire logic RX_SYNCED,
  input wire logic RX_OVERFLOW,
  input wire logic DEV_READY
);
  timeunit 1ns;
  timeprecision 100ps;
  int rel_cnt;
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);
  // saturates so a long run never wraps back into the window
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      rel_cnt <= 0;
    else if (rel_cnt < 1000)
      rel_cnt <= rel_cnt + 1;
  end
  property p_pwr_delay;
    $rose(DEV_READY) |-> rel_cnt inside {[200:202]};
  endproperty
  a_pwr_delay: assert property (p_pwr_delay) else $error("ready delay off");
  property p_tx_gate;
    !DEV_READY |-> !TX_READY && !TX_SERIAL;
  endproperty
  a_tx_gate: assert property (p_tx_gate) else $error("tx active before ready");
  property p_lock_pwr;
    RX_LOCKED |-> DEV_READY;
  endproperty
  a_lock_pwr: assert property (p_lock_pwr) else $error("lock before ready");
  property p_byte_clk;
    $rose(RX_BYTE_CLOCK) |-> RX_BYTE_CLOCK[*5] ##1 !RX_BYTE_CLOCK[*5] ##1 RX_BYTE_CLOCK;
  endproperty
  a_byte_clk: assert property (p_byte_clk) else $error("byte clock pulse wrong");
  property p_sync_rise;
    $rose(RX_SYNCED) |-> RX_LOCKED;
  endproperty
  a_sync_rise: assert property (p_sync_rise) else $error("sync without lock");
  property p_sync_fall;
    $fell(RX_LOCKED) |-> ##[0:1] !RX_SYNCED;
  endproperty
  a_sync_fall: assert property (p_sync_fall) else $error("sync kept after lock loss");
  property p_tx_ovf;
    TX_OVERFLOW && !OVF_CLEAR |=> TX_OVERFLOW;
  endproperty
  a_tx_ovf: assert property (p_tx_ovf) else $error("tx overflow not sticky");
  property p_rx_ovf;
    RX_OVERFLOW && !OVF_CLEAR |=> RX_OVERFLOW;
  endproperty
  a_rx_ovf: assert property (p_rx_ovf) else $error("rx overflow not sticky");
  property p_nib_hold;
    $changed(RX_NIBBLE_BUS) |=> $stable(RX_NIBBLE_BUS)[*4];
  endproperty
  a_nib_hold: assert property (p_nib_hold) else $error("nibble held too short");
endmodule
`default_nettype wire

/* File: verification/sgd_mac_model.sv */
`default_nettype none
module sgd_mac_model
(
  input wire logic run,
  input wire logic [9:0] word,
  output logic tx_clk,
  output logic [4:0] nibble
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    tx_clk = 1'b0;
    nibble = 5'h00;
    forever
    begin
      if (run)
      begin
        nibble = word[4:0];
        #80 tx_clk = 1'b1;
        #80 nibble = word[9:5];
        #80 tx_clk = 1'b0;
        #80;
      end
      else
      begin
        // clock stands still; data wanders so stale nibbles never pass
        #40 nibble = ~nibble;
      end
    end
  end
endmodule
`default_nettype wire

/* File: verification/test_sgd_datapath.sv */
`default_nettype none
module test_sgd_datapath;
  timeunit 1ns;
  timeprecision 100ps;
  import sgd_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  sgd_cfg_t cfg = '0;
  logic ovf_clr = 1'b0;
  logic shared = 1'b1;
  logic mac_run = 1'b0;
  logic [9:0] mac_word = 10'h000;
  logic [9:0] enc_word = 10'h000;
  logic [7:0] dec_data = 8'h00;
  logic rx_on = 1'b0;
  logic [9:0] rx_word = 10'h000;
  logic rx_ser = 1'b0;
  logic [3:0] rx_bit = 4'h0;
  logic mac_clk, tx_ser, tx_rdy, tx_ovf, rx_bc, rx_lock, rx_sync, rx_ovf, dev_rdy;
  logic [4:0] mac_nib, rx_nib;
  logic [9:0] rx_raw;
  int failures = 0;
  int checks_done = 0;
  always #20 ref_clk = ~ref_clk;
  sgd_mac_model mac_u (.run(mac_run), .word(mac_word), .tx_clk(mac_clk), .nibble(mac_nib));
  sgd_datapath dut_u (.REF_CLK(ref_clk), .RST(rst), .CFG(cfg), .OVF_CLEAR(ovf_clr),
    .SHARED_TX_CLOCK(shared & mac_clk), .PER_CHANNEL_TX_CLOCK(~shared & mac_clk),
    .TX_NIBBLE(mac_nib), .ENC_WORD(enc_word), .TX_SERIAL(tx_ser), .TX_READY(tx_rdy),
    .TX_OVERFLOW(tx_ovf), .RX_SERIAL(rx_ser), .RX_RAW_WORD(rx_raw), .DEC_DATA(dec_data),
    .RX_BYTE_CLOCK(rx_bc), .RX_NIBBLE_BUS(rx_nib), .RX_LOCKED(rx_lock), .RX_SYNCED(rx_sync),
    .RX_OVERFLOW(rx_ovf), .DEV_READY(dev_rdy));
  // link partner's serial stream, one bit per reference cycle, lsb first
  always @(posedge ref_clk)
  begin
    #2;
    rx_ser = rx_on & rx_word[rx_bit];
    rx_bit = (rx_bit == 4'h9) ? 4'h0 : rx_bit + 4'h1;
  end
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask
  task automatic check_flag(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic check_word(input string what, input logic [9:0] exp, input logic [9:0] got);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apply_cfg(input logic [5:0] c, input logic sh);
    int i;
    rst = 1'b1;
    cfg = sgd_cfg_t'(c);
    shared = sh;
    step(16);
    rst = 1'b0;
    step(150);
    check_flag("early ready", 1'b0, dev_rdy);
    check_flag("early tx ready", 1'b0, tx_rdy);
    for (i = 0; i < 200 && dev_rdy !== 1'b1; i++) step(1);
    check_flag("ready", 1'b1, dev_rdy);
    check_flag("tx ready", 1'b1, tx_rdy);
  endtask
  task automatic t_tx_word(input logic [5:0] c, input logic sh, input logic [9:0] exp);
    logic [9:0] got;
    int i;
    apply_cfg(c, sh);
    mac_word = 10'h2B5;
    enc_word = 10'h0F1;
    mac_run = 1'b1;
    @(posedge mac_clk);
    mac_run = 1'b0;
    for (i = 0; i < 40 && tx_ser !== 1'b1; i++) step(1);
    for (i = 0; i < 10; i++)
    begin
      got[i] = tx_ser;
      step(1);
    end
    check_word("serial word", exp, got);
  endtask
  task automatic t_tx_overflow;
    apply_cfg(6'b100100, 1'b1);
    mac_word = 10'h155;
    mac_run = 1'b1;
    step(400);
    mac_run = 1'b0;
    check_flag("tx overflow", 1'b1, tx_ovf);
    step(40);
    check_flag("tx overflow held", 1'b1, tx_ovf);
    check_flag("tx ready after drain", 1'b1, tx_rdy);
    ovf_clr = 1'b1;
    step(1);
    ovf_clr = 1'b0;
    step(2);
    check_flag("tx overflow cleared", 1'b0, tx_ovf);
  endtask
  task automatic t_rx_align(input logic [5:0] c, input logic [9:0] w, input logic [4:0] lo, input logic [4:0] hi);
    int i;
    apply_cfg(c, 1'b1);
    rx_word = w;
    rx_on = 1'b1;
    for (i = 0; i < 60 && rx_lock !== 1'b1; i++) step(1);
    check_flag("rx locked", 1'b1, rx_lock);
    step(40);
    check_flag("rx synced", 1'b1, rx_sync);
    check_word("raw word", w, rx_raw);
    @(posedge rx_bc);
    step(1);
    check_word("low nibble", {5'h00, lo}, {5'h00, rx_nib});
    step(5);
    check_word("high nibble", {5'h00, hi}, {5'h00, rx_nib});
    rx_on = 1'b0;
    for (i = 0; i < 40 && rx_lock !== 1'b0; i++) step(1);
    check_flag("lock lost", 1'b0, rx_lock);
  endtask
  task automatic t_rx_nosync(input logic [5:0] c, input logic [9:0] w);
    apply_cfg(c, 1'b1);
    rx_word = w;
    rx_on = 1'b1;
    step(120);
    check_flag("rx locked", 1'b1, rx_lock);
    check_flag("no sync", 1'b0, rx_sync);
    check_flag("rx overflow", 1'b0, rx_ovf);
    rx_on = 1'b0;
  endtask
  task automatic print_verdict;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    #600000;
    failures++;
    print_verdict();
  end
  initial
  begin
    t_tx_word(6'b100100, 1'b1, 10'h2B5);
    t_tx_word(6'b000100, 1'b0, 10'h2B5);
    t_tx_word(6'b110100, 1'b1, 10'h0F1);
    t_tx_overflow();
    t_rx_align(6'b100100, 10'h17C, 5'h1C, 5'h0B);
    t_rx_align(6'b100101, 10'h17C, 5'h1C, 5'h0B);
    t_rx_align(6'b111101, 10'h17C, 5'h1C, 5'h1B);
    t_rx_align(6'b100110, 10'h21E, 5'h1E, 5'h10);
    t_rx_nosync(6'b100100, 10'h283);
    t_rx_nosync(6'b100000, 10'h17C);
    print_verdict();
  end
endmodule
bind sgd_datapath sgd_datapath_monitor mon_u (.REF_CLK(REF_CLK), .RST(RST), .OVF_CLEAR(OVF_CLEAR),
  .TX_SERIAL(TX_SERIAL), .TX_READY(TX_READY), .TX_OVERFLOW(TX_OVERFLOW), .RX_BYTE_CLOCK(RX_BYTE_CLOCK),
  .RX_NIBBLE_BUS(RX_NIBBLE_BUS), .RX_LOCKED(RX_LOCKED), .RX_SYNCED(RX_SYNCED),
  .RX_OVERFLOW(RX_OVERFLOW), .DEV_READY(DEV_READY));
`default_nettype wire
